// ===== design/fpc_pkg.sv
// Package for the flash power, identity and one-time-sector command block.
// Assumes a 40 MHz system clock and a serial link clock from the host.
`default_nettype none
package fpc_pkg;
  // Opcodes
  localparam logic [7:0] OP_SLEEP      = 8'hB9;
  localparam logic [7:0] OP_WAKE_ID    = 8'hAB;
  localparam logic [7:0] OP_MFR_DEV    = 8'h90;
  localparam logic [7:0] OP_IDENT3     = 8'h9F;
  localparam logic [7:0] OP_OTP_ENTER  = 8'h3A;
  localparam logic [7:0] OP_WR_DISABLE = 8'h04;
  localparam logic [7:0] OP_WR_ENABLE  = 8'h06;
  localparam logic [7:0] OP_STAT_READ  = 8'h05;
  localparam logic [7:0] OP_STAT_WRITE = 8'h01;
  localparam logic [7:0] OP_SECT_ERASE = 8'h20;
  localparam logic [7:0] OP_HBLK_ERASE = 8'h52;
  localparam logic [7:0] OP_BLK_ERASE  = 8'hD8;
  localparam logic [7:0] OP_CHIP_ERA1  = 8'hC7;
  localparam logic [7:0] OP_CHIP_ERA2  = 8'h60;
  localparam logic [7:0] OP_PAGE_PROG  = 8'h02;
  // Identity values (arbitrary, neutral)
  localparam logic [7:0] MFR_CODE      = 8'h5A;
  localparam logic [7:0] MEM_TYPE      = 8'h30;
  localparam logic [7:0] CAPACITY      = 8'h13;
  localparam logic [7:0] PART_CODE     = 8'h12;
  // Identifier start addresses
  localparam logic [23:0] MD_ADDR_MFR  = 24'h000000;
  localparam logic [23:0] MD_ADDR_DEV  = 24'h000001;
  // One-time sector window
  localparam logic [23:0] OTP_LO       = 24'h07F000;
  localparam logic [23:0] OTP_HI       = 24'h07F1FF;
  // Status bit positions
  localparam int ST_WIP = 0;
  localparam int ST_WEL = 1;
  localparam int ST_PROT = 7;
  // Timing, ns and derived cycles at 40 MHz
  localparam int CLK_NS        = 25;
  localparam int SLEEP_ENTRY_NS = 3000;
  localparam int WAKE_DELAY_NS  = 3000;
  localparam int ERASE_NS       = 30000;
  localparam int SLEEP_ENTRY_CYC = (SLEEP_ENTRY_NS + CLK_NS - 1) / CLK_NS;
  localparam int WAKE_DELAY_CYC  = (WAKE_DELAY_NS + CLK_NS - 1) / CLK_NS;
  localparam int ERASE_CYC       = (ERASE_NS + CLK_NS - 1) / CLK_NS;
  localparam int CNT_W = 16;

  typedef enum logic [1:0] {
    FPC_STANDBY  = 2'b00,
    FPC_ENTERING = 2'b01,
    FPC_SLEEP    = 2'b10,
    FPC_WAKING   = 2'b11
  } fpc_pwr_t;

  // Completed frame handed from link domain to system domain
  typedef struct packed {
    logic [7:0]  opcode;
    logic [23:0] addr;
    logic [7:0]  data;
    logic [5:0]  bits;
  } fpc_frame_t;

  // Status passed to the link domain
  typedef struct packed {
    logic       sleep;
    logic       busy;
    logic       otp_mode;
    logic [7:0] status;
  } fpc_state_t;
endpackage
`default_nettype wire

// ===== design/fpc_top.sv
// Flash command block: sleep, wake, part code read outside sleep, identity reads, one-time sector mode.
// Assumes host drives cs, sclk and lines; sclk only toggles while cs is low.
`default_nettype none
module fpc_top (
  input  wire logic            clk,
  input  wire logic            rst_b,
  input  wire logic            sclk,
  input  wire logic            cs_b,
  input  wire logic [3:0]      dq_in,
  output logic      [3:0]      dq_out,
  output logic      [3:0]      dq_oe,
  input  wire logic            quad_command_mode_entry,
  output logic                 sleep_active,
  output logic                 otp_mode,
  output logic                 otp_map_hit,
  output logic                 array_write_allowed,
  output logic                 write_in_progress_flag,
  output logic                 write_enable_latch,
  output logic [7:0]           status_byte
);
  import fpc_pkg::*;

  // ---------------- Link domain ----------------
  logic        q_l1_r, q_l2_r;
  logic        sleep_r, busy_r, otp_r, lock_r, wel_r;
  logic [7:0]  stat_nxt;
  logic [7:0]  fr_op_r;
  logic [23:0] fr_addr_r;
  logic [7:0]  fr_data_r;
  fpc_state_t  st_l1_r, st_l2_r;
  fpc_frame_t  frm_r;
  logic [5:0]  cnt_r;
  logic [31:0] sh_r;
  logic [7:0]  obyte_r;
  logic [2:0]  obit_r;
  logic [1:0]  osel_r;
  logic [3:0]  out_r;
  logic [3:0]  oe_r;
  logic        done_tog_r;
  logic [5:0]  cnt_nxt;
  logic [31:0] sh_nxt;
  logic        quad;
  logic        reading;

  // Mode and state used on the link side come through two stages
  always_ff @(posedge sclk or negedge rst_b) begin
    if (!rst_b) begin
      q_l1_r  <= 1'b0;
      q_l2_r  <= 1'b0;
      st_l1_r <= '0;
      st_l2_r <= '0;
    end else begin
      q_l1_r  <= quad_command_mode_entry;
      q_l2_r  <= q_l1_r;
      st_l1_r <= {sleep_r, busy_r, otp_r, stat_nxt};
      st_l2_r <= st_l1_r;
    end
  end

  assign quad = q_l2_r;

  always_comb begin
    cnt_nxt = cnt_r + (quad ? 6'd4 : 6'd1);
    sh_nxt  = quad ? {sh_r[27:0], dq_in} : {sh_r[30:0], dq_in[0]};
  end

  // Capture of opcode and address on rising edges; cs high clears
  always_ff @(posedge sclk or posedge cs_b) begin
    if (cs_b) begin
      cnt_r <= 6'd0;
      sh_r  <= '0;
    end else begin
      if (cnt_r != 6'h3F) begin
        cnt_r <= (cnt_nxt < cnt_r) ? 6'h3F : cnt_nxt;
      end
      sh_r <= sh_nxt;
    end
  end

  // Frame snapshot; the toggle marks each frame end for the system side
  always_ff @(posedge cs_b or negedge rst_b) begin
    if (!rst_b) begin
      done_tog_r <= 1'b0;
      frm_r      <= '0;
    end else begin
      done_tog_r      <= ~done_tog_r;
      frm_r.bits      <= cnt_r;
      frm_r.opcode    <= (cnt_r >= 6'd8) ? fr_op_r : 8'h00;
      frm_r.addr      <= fr_addr_r;
      frm_r.data      <= fr_data_r;
    end
  end

  always_ff @(posedge sclk or negedge rst_b) begin
    if (!rst_b) begin
      fr_op_r   <= 8'h00;
      fr_addr_r <= 24'h000000;
      fr_data_r <= 8'h00;
    end else begin
      if (cnt_nxt == 6'd8)  fr_op_r   <= sh_nxt[7:0];
      if (cnt_nxt == 6'd32) fr_addr_r <= sh_nxt[23:0];
      if (cnt_nxt == 6'd40) fr_data_r <= sh_nxt[7:0];
    end
  end

  // Output shifting on falling edges
  always_ff @(negedge sclk or posedge cs_b) begin
    if (cs_b) begin
      obit_r  <= 3'd7;
      osel_r  <= 2'd0;
      oe_r    <= 4'h0;
      out_r   <= 4'h0;
    end else begin
      oe_r <= 4'h0;
      if (reading && !st_l2_r.sleep) begin
        oe_r    <= quad ? 4'hF : 4'h2;
        out_r   <= quad ? (obit_r[2] ? obyte_r[7:4] : obyte_r[3:0]) : {3'b000, 1'b0} | {2'b00, obyte_r[obit_r], 1'b0};
        if (quad ? (obit_r[2] == 1'b0) : (obit_r == 3'd0)) begin
          osel_r <= osel_r + 2'd1;
          obit_r <= 3'd7;
        end else begin
          obit_r <= quad ? 3'd3 : obit_r - 3'd1;
        end
      end
    end
  end

  // Which byte and when output starts
  always_comb begin
    reading = 1'b0;
    obyte_r = 8'h00;
    case (fr_op_r)
      OP_WAKE_ID: begin
        reading = (cnt_r >= 6'd32) && !st_l2_r.busy;
        obyte_r = PART_CODE;
      end
      OP_MFR_DEV: begin
        reading = (cnt_r >= 6'd32) && !st_l2_r.busy && !st_l2_r.sleep;
        obyte_r = ((osel_r[0] ^ (fr_addr_r == MD_ADDR_DEV)) ? PART_CODE : MFR_CODE);
      end
      OP_IDENT3: begin
        reading = (cnt_r >= 6'd8) && (cnt_r < 6'd32) && !st_l2_r.busy && !st_l2_r.sleep;
        obyte_r = (osel_r == 2'd0) ? MFR_CODE : (osel_r == 2'd1) ? MEM_TYPE : CAPACITY;
      end
      OP_STAT_READ: begin
        reading = (cnt_r >= 6'd8) && !st_l2_r.sleep;
        obyte_r = st_l2_r.status;
      end
      default: begin
        reading = 1'b0;
        obyte_r = 8'h00;
      end
    endcase
  end

  // ---------------- System domain ----------------
  logic       tog_s1_r, tog_s2_r, tog_s3_r;
  fpc_pwr_t   pwr_r;
  logic [CNT_W-1:0] tmr_r, erase_r;
  logic       frame_evt;
  logic [7:0] op;
  logic       whole8;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      tog_s1_r <= 1'b0;
      tog_s2_r <= 1'b0;
      tog_s3_r <= 1'b0;
    end else begin
      tog_s1_r <= done_tog_r;
      tog_s2_r <= tog_s1_r;
      tog_s3_r <= tog_s2_r;
    end
  end

  assign frame_evt = tog_s2_r ^ tog_s3_r;
  assign op        = frm_r.opcode;
  assign whole8    = (frm_r.bits == 6'd8);

  // Power state; reset is power-up into standby
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pwr_r <= FPC_STANDBY;
      tmr_r <= '0;
    end else begin
      case (pwr_r)
        FPC_STANDBY: begin
          if (frame_evt && op == OP_SLEEP && whole8 && !busy_r) begin
            pwr_r <= FPC_ENTERING;
            tmr_r <= CNT_W'(SLEEP_ENTRY_CYC);
          end
        end
        FPC_ENTERING: begin
          if (tmr_r <= CNT_W'(1)) pwr_r <= FPC_SLEEP;
          else tmr_r <= tmr_r - CNT_W'(1);
        end
        FPC_SLEEP: begin
          if (frame_evt && op == OP_WAKE_ID) begin
            pwr_r <= FPC_WAKING;
            tmr_r <= CNT_W'(WAKE_DELAY_CYC);
          end
        end
        FPC_WAKING: begin
          if (tmr_r <= CNT_W'(1)) pwr_r <= FPC_STANDBY;
          else tmr_r <= tmr_r - CNT_W'(1);
        end
        default: pwr_r <= FPC_STANDBY;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) sleep_r <= 1'b0;
    else sleep_r <= (pwr_r != FPC_STANDBY) && (pwr_r != FPC_ENTERING);
  end

  logic cmd_ok;
  assign cmd_ok = frame_evt && (pwr_r == FPC_STANDBY);

  logic erase_req;
  logic era_ok_addr;
  assign era_ok_addr = !otp_r || (frm_r.addr >= OTP_LO && frm_r.addr <= OTP_HI) || !lock_r;
  assign erase_req = cmd_ok && !busy_r && wel_r && frm_r.bits == 6'd32 && era_ok_addr &&
                     ((op == OP_SECT_ERASE) ||
                      (!otp_r && (op == OP_HBLK_ERASE || op == OP_BLK_ERASE))) ||
                     (cmd_ok && !busy_r && wel_r && whole8 && !otp_r &&
                      (op == OP_CHIP_ERA1 || op == OP_CHIP_ERA2));

  // Self-timed erase cycle and write enable latch
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      busy_r  <= 1'b0;
      erase_r <= '0;
      wel_r   <= 1'b0;
    end else begin
      if (erase_req) begin
        busy_r  <= 1'b1;
        erase_r <= CNT_W'(ERASE_CYC);
      end else if (busy_r) begin
        if (erase_r == CNT_W'(2)) wel_r <= 1'b0;
        if (erase_r <= CNT_W'(1)) busy_r <= 1'b0;
        else erase_r <= erase_r - CNT_W'(1);
      end
      if (cmd_ok && !busy_r && whole8 && op == OP_WR_ENABLE) wel_r <= 1'b1;
      if (cmd_ok && !busy_r && whole8 && op == OP_WR_DISABLE) wel_r <= 1'b0;
    end
  end

  // One-time sector mode and its lock
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      otp_r  <= 1'b0;
      lock_r <= 1'b0;
    end else begin
      if (cmd_ok && !busy_r && whole8 && op == OP_OTP_ENTER) otp_r <= 1'b1;
      if (cmd_ok && !busy_r && whole8 && op == OP_WR_DISABLE) otp_r <= 1'b0;
      if (cmd_ok && !busy_r && otp_r && wel_r && op == OP_STAT_WRITE && frm_r.bits == 6'd16)
        lock_r <= 1'b1;
    end
  end

  always_comb begin
    stat_nxt = 8'h00;
    stat_nxt[ST_WIP]  = busy_r;
    stat_nxt[ST_WEL]  = wel_r;
    stat_nxt[ST_PROT] = otp_r ? lock_r : 1'b0;
  end

  // Registered outputs
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      sleep_active           <= 1'b0;
      otp_mode               <= 1'b0;
      otp_map_hit            <= 1'b0;
      array_write_allowed    <= 1'b0;
      write_in_progress_flag <= 1'b0;
      write_enable_latch     <= 1'b0;
      status_byte            <= 8'h00;
    end else begin
      sleep_active           <= sleep_r;
      otp_mode               <= otp_r;
      otp_map_hit            <= otp_r && frm_r.addr >= OTP_LO && frm_r.addr <= OTP_HI;
      array_write_allowed    <= wel_r && !busy_r && !sleep_r && (!otp_r || !lock_r);
      write_in_progress_flag <= busy_r;
      write_enable_latch     <= wel_r;
      status_byte            <= stat_nxt;
    end
  end

  // Pin drive on the link side, released while deselected or asleep
  // Both come from link-side flops that clear at once when select rises
  assign dq_out = out_r;
  assign dq_oe  = oe_r;
endmodule
`default_nettype wire

// ===== testbench/fpc_host_model.sv
// Host side of the serial link: select, link clock and command lines.
// Assumes mode 0 framing; the link clock stands low outside frames.
`default_nettype none
module fpc_host_model (
  output var logic       sclk,
  output var logic       cs_b,
  output var logic [3:0] host_dq,
  input  wire logic      dq_line,
  input  wire logic [3:0] dq_all
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    sclk = 1'b0;
    cs_b = 1'b1;
    host_dq = 4'h5;
  end
  // Lines not carrying a command bit toggle so stale values never look valid
  task automatic frame(input logic [39:0] tx, input int ntx, input int nrx, output logic [31:0] rx);
    rx = 32'h0;
    cs_b = 1'b0;
    for (int i = 0; i < ntx + nrx; i++) begin
      host_dq[3:1] = ~host_dq[3:1];
      host_dq[0] = (i < ntx) ? tx[39-i] : ~host_dq[0];
      #16 sclk = 1'b1;
      if (i >= ntx) rx = {rx[30:0], dq_line};
      #16 sclk = 1'b0;
    end
    #16 cs_b = 1'b1;
    host_dq = ~host_dq;
  endtask
  // Four-line frame: counts are in nibbles
  task automatic frame4(input logic [39:0] tx, input int ntx, input int nrx, output logic [31:0] rx);
    rx = 32'h0;
    cs_b = 1'b0;
    for (int i = 0; i < ntx + nrx; i++) begin
      host_dq = (i < ntx) ? tx[39-4*i -: 4] : ~host_dq;
      #16 sclk = 1'b1;
      if (i >= ntx) rx = {rx[27:0], dq_all};
      #16 sclk = 1'b0;
    end
    #16 cs_b = 1'b1;
    host_dq = ~host_dq;
  endtask
endmodule
`default_nettype wire

// ===== testbench/fpc_properties.sv
// Checker for the flash command block, watching only the top ports.
// Assumes clk is the system clock and rst_b the asynchronous power-on reset.
`default_nettype none
module fpc_checker (
  input wire logic       clk,
  input wire logic       rst_b,
  input wire logic       sclk,
  input wire logic       cs_b,
  input wire logic [3:0] dq_in,
  input wire logic [3:0] dq_out,
  input wire logic [3:0] dq_oe,
  input wire logic       quad_command_mode_entry,
  input wire logic       sleep_active,
  input wire logic       otp_mode,
  input wire logic       otp_map_hit,
  input wire logic       array_write_allowed,
  input wire logic       write_in_progress_flag,
  input wire logic       write_enable_latch,
  input wire logic [7:0] status_byte
);
  import fpc_pkg::*;
  logic [15:0] cs_hi_r;
  logic [15:0] wip_cnt_r;
  // Cycles since select last went high
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) cs_hi_r <= 16'h0000;
    else if (!cs_b) cs_hi_r <= 16'h0000;
    else if (cs_hi_r != 16'hFFFF) cs_hi_r <= cs_hi_r + 16'h0001;
  end
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) wip_cnt_r <= 16'h0000;
    else if (!write_in_progress_flag) wip_cnt_r <= 16'h0000;
    else wip_cnt_r <= wip_cnt_r + 16'h0001;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  chk_sleep_entry_delay: assert property ($rose(sleep_active) |-> cs_hi_r >= SLEEP_ENTRY_CYC)
    else $error("sleep entered too early");
  chk_wake_delay: assert property ($fell(sleep_active) |-> cs_hi_r >= WAKE_DELAY_CYC)
    else $error("wake finished too early");
  chk_sleep_not_busy: assert property (sleep_active |-> !write_in_progress_flag)
    else $error("sleep during busy cycle");
  chk_lines_released: assert property ((cs_b && $past(cs_b)) || sleep_active |-> dq_oe == 4'h0)
    else $error("data lines driven while idle");
  chk_status_mirror: assert property (status_byte[ST_WIP] == write_in_progress_flag &&
    status_byte[ST_WEL] == write_enable_latch) else $error("status bits disagree");
  chk_latch_cleared: assert property ($fell(write_in_progress_flag) |-> !write_enable_latch)
    else $error("latch still set after erase");
  chk_erase_length: assert property ($fell(write_in_progress_flag) |->
    wip_cnt_r >= ERASE_CYC - 2 && wip_cnt_r <= ERASE_CYC + 4) else $error("erase length wrong");
  chk_otp_window: assert property (otp_map_hit |-> otp_mode)
    else $error("sector remap outside one-time mode");
  chk_lock_holds: assert property (otp_mode && $past(otp_mode) && $past(status_byte[ST_PROT]) |->
    status_byte[ST_PROT]) else $error("lock bit cleared");
  chk_lock_blocks: assert property (otp_mode && status_byte[ST_PROT] |-> !array_write_allowed)
    else $error("array writable with lock set");
  chk_mode_change: assert property ($changed(otp_mode) |-> cs_b && $past(cs_b, 2))
    else $error("mode changed inside a frame");
  cov_sleep: cover property ($rose(sleep_active));
  cov_erase: cover property ($fell(write_in_progress_flag));
  cov_lock: cover property (otp_mode && status_byte[ST_PROT]);
endmodule
bind fpc_top fpc_checker chk_u (.clk(clk), .rst_b(rst_b), .sclk(sclk), .cs_b(cs_b), .dq_in(dq_in),
  .dq_out(dq_out), .dq_oe(dq_oe), .quad_command_mode_entry(quad_command_mode_entry),
  .sleep_active(sleep_active), .otp_mode(otp_mode), .otp_map_hit(otp_map_hit),
  .array_write_allowed(array_write_allowed), .write_in_progress_flag(write_in_progress_flag),
  .write_enable_latch(write_enable_latch), .status_byte(status_byte));
`default_nettype wire

// ===== testbench/testbench.sv
// Self-checking bench for the flash command block.
// Assumes the host model drives the link; the bench drives reset and mode.
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  import fpc_pkg::*;
  logic        clk = 1'b0;
  logic        rst_b = 1'b0;
  logic        quad_mode = 1'b0;
  wire         sclk, cs_b;
  wire  [3:0]  host_dq, dq_w;
  logic [3:0]  dq_out, dq_oe;
  logic        sleep_active, otp_mode, otp_map_hit, array_write_allowed, write_in_progress_flag;
  logic        write_enable_latch;
  logic [7:0]  status_byte;
  logic [31:0] rx;
  logic [7:0]  rnd;
  int          err_count = 0;
  int          checks_done = 0;
  int          cyc = 0;
  assign dq_w = (dq_oe & dq_out) | (~dq_oe & host_dq);
  fpc_top dut_u (.clk(clk), .rst_b(rst_b), .sclk(sclk), .cs_b(cs_b), .dq_in(dq_w), .dq_out(dq_out),
    .dq_oe(dq_oe), .quad_command_mode_entry(quad_mode), .sleep_active(sleep_active),
    .otp_mode(otp_mode), .otp_map_hit(otp_map_hit), .array_write_allowed(array_write_allowed),
    .write_in_progress_flag(write_in_progress_flag), .write_enable_latch(write_enable_latch),
    .status_byte(status_byte));
  fpc_host_model host_u (.sclk(sclk), .cs_b(cs_b), .host_dq(host_dq), .dq_line(dq_w[1]), .dq_all(dq_w));
  initial begin
    forever #12.5 clk = ~clk;
  end
  task automatic test_done;
    $display("checks=%0d errors=%0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 12000) begin
      err_count++;
      test_done();
    end
  end
  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk_flag(input logic got, input logic exp);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR t=%0t flag got=%h exp=%h", $time, got, exp);
    end
  endtask
  function automatic logic [31:0] exp_md(input logic dev_first);
    return dev_first ? {16'h0, PART_CODE, MFR_CODE} : {16'h0, MFR_CODE, PART_CODE};
  endfunction
  task automatic idle(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic send(input logic [7:0] op, input logic [31:0] arg, input int ntx, input int nrx);
    @(negedge clk);
    host_u.frame({op, arg}, ntx, nrx, rx);
    idle(12);
  endtask
  task automatic wait_idle;
    for (int i = 0; i < ERASE_CYC + 50 && write_in_progress_flag !== 1'b0; i++) idle(1);
  endtask
  initial begin
    void'($urandom(70388));
    idle(20);
    rst_b = 1'b1;
    idle(4);
    chk_flag(sleep_active, 1'b0);
    send(OP_IDENT3, 32'h0, 8, 24);
    chk_word(rx, {8'h00, MFR_CODE, MEM_TYPE, CAPACITY});
    for (int i = 0; i < 4; i++) begin
      rnd = 8'($urandom);
      send(OP_MFR_DEV, {23'h0, rnd[0], 8'h00}, 32, 16);
      chk_word(rx, exp_md(rnd[0]));
    end
    send(OP_WAKE_ID, $urandom, 32, 16);
    chk_word(rx, {16'h0, PART_CODE, PART_CODE});
    send(OP_SLEEP, 32'h0, 9, 0);
    idle(SLEEP_ENTRY_CYC + 10);
    chk_flag(sleep_active, 1'b0);
    send(OP_SLEEP, 32'h0, 8, 0);
    idle(SLEEP_ENTRY_CYC + 10);
    chk_flag(sleep_active, 1'b1);
    // Maker read instead of the three-byte read while asleep
    send(OP_WR_ENABLE, 32'h0, 8, 0);
    send(OP_MFR_DEV, 32'h0, 32, 16);
    chk_flag(write_enable_latch, 1'b0);
    chk_flag(sleep_active, 1'b1);
    send(OP_WAKE_ID, 32'h0, 8, 0);
    idle(WAKE_DELAY_CYC + 10);
    chk_flag(sleep_active, 1'b0);
    send(OP_WR_ENABLE, 32'h0, 8, 0);
    chk_flag(write_enable_latch, 1'b1);
    send(OP_SECT_ERASE, {5'h00, 19'($urandom), 8'h00}, 32, 0);
    chk_flag(write_in_progress_flag, 1'b1);
    send(OP_SLEEP, 32'h0, 8, 0);
    send(OP_WAKE_ID, 32'h0, 8, 0);
    idle(SLEEP_ENTRY_CYC + 10);
    chk_flag(sleep_active, 1'b0);
    chk_flag(write_in_progress_flag, 1'b1);
    wait_idle();
    chk_flag(write_in_progress_flag, 1'b0);
    chk_flag(write_enable_latch, 1'b0);
    send(OP_OTP_ENTER, 32'h0, 8, 0);
    chk_flag(otp_mode, 1'b1);
    send(OP_WR_ENABLE, 32'h0, 8, 0);
    send(OP_STAT_WRITE, {8'($urandom), 24'h0}, 16, 0);
    wait_idle();
    chk_flag(status_byte[ST_PROT], 1'b1);
    chk_flag(array_write_allowed, 1'b0);
    send(OP_STAT_READ, 32'h0, 8, 8);
    chk_flag(rx[ST_PROT], 1'b1);
    send(OP_WR_ENABLE, 32'h0, 8, 0);
    send(OP_CHIP_ERA1, 32'h0, 8, 0);
    chk_flag(write_in_progress_flag, 1'b0);
    send(OP_WR_DISABLE, 32'h0, 8, 0);
    chk_flag(otp_mode, 1'b0);
    send(OP_SLEEP, 32'h0, 8, 0);
    idle(SLEEP_ENTRY_CYC + 10);
    rst_b = 1'b0;
    idle(3);
    rst_b = 1'b1;
    idle(4);
    chk_flag(sleep_active, 1'b0);
    // Four-line mode; the first frame lets the mode level reach the link side
    quad_mode = 1'b1;
    @(negedge clk);
    host_u.frame4(40'h0, 2, 0, rx);
    idle(12);
    host_u.frame4({OP_IDENT3, 32'h0}, 2, 6, rx);
    idle(12);
    chk_word(rx, {8'h00, MFR_CODE, MEM_TYPE, CAPACITY});
    test_done();
  end
endmodule
`default_nettype wire
